//--- design/pfcsv_defs.svh
// Constants for the boost and resonant protection supervisor
`ifndef PFCSV_DEFS_SVH
`define PFCSV_DEFS_SVH

// ****************************************
// Clock and time conversion
// ****************************************
`define PFCSV_CLK_MHZ 200
`define PFCSV_CYC_UP(ns) ((((ns) * `PFCSV_CLK_MHZ) + 999) / 1000)
`define PFCSV_CYC_DN(ns) (((ns) * `PFCSV_CLK_MHZ) / 1000)

// ****************************************
// Register byte offsets
// ****************************************
`define PFCSV_CTRL_OFS 8'h00
`define PFCSV_MAINS_OFS 8'h04
`define PFCSV_SUPPLY_OFS 8'h08
`define PFCSV_CAPAV_OFS 8'h0C
`define PFCSV_STATUS_OFS 8'h10
`define PFCSV_FLAGS_OFS 8'h14

// ****************************************
// Reset values and writable masks
// ****************************************
`define PFCSV_CTRL_RST 32'h0000_0830
`define PFCSV_MAINS_RST 32'h0140_0100
`define PFCSV_SUPPLY_RST 32'h0000_00D0
`define PFCSV_CAPAV_RST 32'h0010_03F0
`define PFCSV_CTRL_MASK 32'h0000_0F3F
`define PFCSV_MAINS_MASK 32'h03FF_03FF
`define PFCSV_SUPPLY_MASK 32'h0000_00FF
`define PFCSV_CAPAV_MASK 32'h03FF_03FF

// ****************************************
// Control field positions
// ****************************************
`define PFCSV_CTRL_FD_PROT 0
`define PFCSV_CTRL_FD_CLR 1
`define PFCSV_CTRL_BO_LLC 2
`define PFCSV_CTRL_OVP_LLC 3
`define PFCSV_CTRL_SUP_EN 4
`define PFCSV_CTRL_LOCP_EN 5
`define PFCSV_CTRL_COIL_LSB 8

// ****************************************
// Sense levels in converter codes
// ****************************************
`define PFCSV_SCP_START 10'h040
`define PFCSV_SCP_STOP 10'h030
`define PFCSV_BOOST_START 10'h280
`define PFCSV_BOOST_UVP 10'h200
`define PFCSV_BOOST_REG 10'h330
`define PFCSV_OVP_STOP 10'h360
`define PFCSV_NTC_DET 10'h080
`define PFCSV_PEAK_HYST 10'h010
`define PFCSV_LLC_OCP 10'sh1C0

// ****************************************
// Times in ns
// ****************************************
`define PFCSV_OTP_NS 2000
`define PFCSV_NTC_MAX_NS 4000
`define PFCSV_OCP_FILT_NS 160
`define PFCSV_LEB_NS 300
`define PFCSV_FLR_NS 10000
`define PFCSV_BO_NS 15000
`define PFCSV_BO_LLC_NS 20000
`define PFCSV_OVP_PER_NS 5000
`define PFCSV_DRAIN_NS 1000
`define PFCSV_SUP_NS 5000
`define PFCSV_LOCP_NS 10000

`endif

//--- design/pfcsv_pkg.sv
// Types shared by the protection supervisor
package pfcsv_pkg;
  typedef logic [9:0] pfcsv_adc_t;
  typedef logic [11:0] pfcsv_cnt_t;
  typedef enum logic {NTC_IDLE, NTC_MEAS} pfcsv_ntc_e;
endpackage

//--- design/pfcsv_top.sv
// Protection supervisor gating the boost and resonant stages
`timescale 1ns/1ps
`include "pfcsv_defs.svh"

// Operation
// - Track mains peak, store it, drive brownout
// - Thermistor current source on at mains peak
// - Low thermistor voltage trips over-temperature after delay
// - Source off at threshold or maximum time
// - No switching until boost above short start
// - Fast disable stops or enters protection
// - Stop-only fast disable may clear all protections
// - Boost resumes at short start, resonant later
// - Brownout soft-stops boost, optionally resonant too
// - Boost overvoltage inhibits boost until regulation level
// - Persistent boost overvoltage may stop resonant stage
// - Drain comparator blanked after boost turn-off
// - Drain overvoltage enters protection after delay
// - Boost overcurrent cuts gate, cycle restart gated
// - Boost overcurrent filtered against turn-on spikes
// - Overcurrent every cycle for N cycles protects
// - High-side gate off on high-side supply low
// - Resonant stage runs with boost start hysteresis
// - Supply overvoltage with delay, can be disabled
// - Cut active switch when resonant current nears zero
// - Resonant overcurrent cut, persistent overcurrent protects
module pfcsv_top
  import pfcsv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [9:0] mains_sense_pin_i,
  input wire logic [9:0] boost_sense_pin_i,
  input wire logic [7:0] ic_supply_pin_i,
  input wire logic boost_drain_pin_i,
  input wire logic boost_current_sense_pin_i,
  input wire logic boost_cycle_start_i,
  input wire logic boost_on_req_i,
  input wire logic signed [9:0] resonant_current_sense_pin_i,
  input wire logic high_side_req_i,
  input wire logic low_side_req_i,
  input wire logic high_side_supply_low_i,
  output logic ntc_source_en_o,
  output logic boost_gate_o,
  output logic high_side_gate_o,
  output logic low_side_gate_o,
  output logic boost_soft_stop_o,
  output logic protection_o
);

  // ****************************************
  // Timing counts
  // ****************************************
  localparam int NTC_MAX_C = `PFCSV_CYC_DN(`PFCSV_NTC_MAX_NS);
  localparam int OTP_C = `PFCSV_CYC_UP(`PFCSV_OTP_NS);
  localparam int FILT_C = `PFCSV_CYC_UP(`PFCSV_OCP_FILT_NS);
  localparam int LEB_C = `PFCSV_CYC_UP(`PFCSV_LEB_NS);
  localparam int NP = 7;
  localparam pfcsv_cnt_t [NP-1:0] LIM = {
    12'(`PFCSV_CYC_UP(`PFCSV_LOCP_NS)), 12'(`PFCSV_CYC_UP(`PFCSV_SUP_NS)),
    12'(`PFCSV_CYC_UP(`PFCSV_DRAIN_NS)), 12'(`PFCSV_CYC_UP(`PFCSV_OVP_PER_NS)),
    12'(`PFCSV_CYC_UP(`PFCSV_BO_LLC_NS)), 12'(`PFCSV_CYC_UP(`PFCSV_BO_NS)),
    12'(`PFCSV_CYC_UP(`PFCSV_FLR_NS))};
  localparam int P_FLR = 0;
  localparam int P_BO = 1;
  localparam int P_BOLLC = 2;
  localparam int P_OVP = 3;
  localparam int P_DRAIN = 4;
  localparam int P_SUP = 5;
  localparam int P_LOCP = 6;

  logic [31:0] ctrl_reg;
  logic [31:0] mains_reg;
  logic [31:0] supply_reg;
  logic [31:0] capav_reg;
  logic [5:0] flags_reg;
  logic [5:0] flags_set;
  logic [5:0] flags_clr;
  logic prot_act;
  logic [NP-1:0] p_cond;
  logic [NP-1:0] p_hit;

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic wb_req;
  logic [31:0] wmask;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `PFCSV_CTRL_RST;
      mains_reg <= `PFCSV_MAINS_RST;
      supply_reg <= `PFCSV_SUPPLY_RST;
      capav_reg <= `PFCSV_CAPAV_RST;
    end else if (wb_req && wb_we_i) begin
      unique case (wb_adr_i)
        `PFCSV_CTRL_OFS: ctrl_reg <= ((ctrl_reg & ~wmask) | (wb_dat_i & wmask)) & `PFCSV_CTRL_MASK;
        `PFCSV_MAINS_OFS: mains_reg <= ((mains_reg & ~wmask) | (wb_dat_i & wmask)) & `PFCSV_MAINS_MASK;
        `PFCSV_SUPPLY_OFS: supply_reg <= ((supply_reg & ~wmask) | (wb_dat_i & wmask)) & `PFCSV_SUPPLY_MASK;
        `PFCSV_CAPAV_OFS: capav_reg <= ((capav_reg & ~wmask) | (wb_dat_i & wmask)) & `PFCSV_CAPAV_MASK;
        default: ;
      endcase
    end
  end

  logic [9:0] peak_reg;
  logic pfc_run_reg;
  logic llc_run_reg;
  logic bo_stop_reg;
  logic ovp_inh_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `PFCSV_CTRL_OFS: wb_dat_o <= ctrl_reg;
        `PFCSV_MAINS_OFS: wb_dat_o <= mains_reg;
        `PFCSV_SUPPLY_OFS: wb_dat_o <= supply_reg;
        `PFCSV_CAPAV_OFS: wb_dat_o <= capav_reg;
        `PFCSV_STATUS_OFS: wb_dat_o <= {6'h00, peak_reg, 10'h000, ntc_source_en_o, ovp_inh_reg,
                                        bo_stop_reg, llc_run_reg, pfc_run_reg, prot_act};
        `PFCSV_FLAGS_OFS: wb_dat_o <= {26'h000_0000, flags_reg};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Persistence timers
  // ****************************************
  generate
    for (genvar k = 0; k < NP; k++) begin : g_pers
      pfcsv_cnt_t cnt_reg;
      always_ff @(posedge clk_i) begin
        if (rst_i || !p_cond[k]) begin
          cnt_reg <= 12'h000;
        end else if (cnt_reg != LIM[k]) begin
          cnt_reg <= cnt_reg + 12'h001;
        end
      end
      assign p_hit[k] = p_cond[k] && (cnt_reg == LIM[k]);
    end
  endgenerate

  // ****************************************
  // Mains peak and thermistor check
  // ****************************************
  logic [9:0] track_reg;
  logic rising_reg;
  logic peak_det;
  pfcsv_ntc_e ntc_state;
  pfcsv_cnt_t ntc_cnt_reg;
  logic ntc_low;
  logic otp_trip;
  logic [10:0] m_ext;
  logic [10:0] t_ext;
  logic [10:0] hyst_ext;
  assign m_ext = {1'b0, mains_sense_pin_i};
  assign t_ext = {1'b0, track_reg};
  assign hyst_ext = {1'b0, `PFCSV_PEAK_HYST};
  assign peak_det = rising_reg && (ntc_state == NTC_IDLE) && (m_ext + hyst_ext < t_ext);
  assign ntc_low = mains_sense_pin_i < `PFCSV_NTC_DET;
  assign otp_trip = (ntc_state == NTC_MEAS) && ntc_low && (ntc_cnt_reg == 12'(OTP_C - 1));

  // Tracker frozen while the source lifts the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      track_reg <= 10'h000;
      rising_reg <= 1'b1;
      peak_reg <= 10'h000;
    end else if (ntc_state == NTC_IDLE) begin
      if (rising_reg) begin
        if (mains_sense_pin_i > track_reg) begin
          track_reg <= mains_sense_pin_i;
        end else if (peak_det) begin
          peak_reg <= track_reg;
          track_reg <= mains_sense_pin_i;
          rising_reg <= 1'b0;
        end
      end else begin
        if (mains_sense_pin_i < track_reg) begin
          track_reg <= mains_sense_pin_i;
        end else if (m_ext > t_ext + hyst_ext) begin
          track_reg <= mains_sense_pin_i;
          rising_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ntc_state <= NTC_IDLE;
      ntc_source_en_o <= 1'b0;
      ntc_cnt_reg <= 12'h000;
    end else begin
      unique case (ntc_state)
        NTC_IDLE: begin
          ntc_cnt_reg <= 12'h000;
          if (peak_det) begin
            ntc_state <= NTC_MEAS;
            ntc_source_en_o <= 1'b1;
          end
        end
        NTC_MEAS: begin
          ntc_cnt_reg <= ntc_cnt_reg + 12'h001;
          if (!ntc_low || ntc_cnt_reg == 12'(NTC_MAX_C - 1)) begin
            ntc_state <= NTC_IDLE;
            ntc_source_en_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Boost sense windows
  // ****************************************
  logic started_reg;
  logic fd_event;
  assign fd_event = started_reg && pfc_run_reg && (boost_sense_pin_i < `PFCSV_SCP_STOP);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pfc_run_reg <= 1'b0;
      llc_run_reg <= 1'b0;
      ovp_inh_reg <= 1'b0;
      started_reg <= 1'b0;
    end else begin
      if (boost_sense_pin_i > `PFCSV_SCP_START) begin
        pfc_run_reg <= 1'b1;
        started_reg <= 1'b1;
      end else if (boost_sense_pin_i < `PFCSV_SCP_STOP) begin
        pfc_run_reg <= 1'b0;
      end
      if (boost_sense_pin_i > `PFCSV_BOOST_START) begin
        llc_run_reg <= 1'b1;
      end else if (boost_sense_pin_i < `PFCSV_BOOST_UVP) begin
        llc_run_reg <= 1'b0;
      end
      if (boost_sense_pin_i > `PFCSV_OVP_STOP) begin
        ovp_inh_reg <= 1'b1;
      end else if (boost_sense_pin_i < `PFCSV_BOOST_REG) begin
        ovp_inh_reg <= 1'b0;
      end
    end
  end

  // Brownout acts on the stored peak, not the instantaneous pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bo_stop_reg <= 1'b1;
    end else if (p_hit[P_BO]) begin
      bo_stop_reg <= 1'b1;
    end else if (peak_reg > mains_reg[25:16]) begin
      bo_stop_reg <= 1'b0;
    end
  end
  assign boost_soft_stop_o = bo_stop_reg;

  // ****************************************
  // Boost gate, current filter, blanking
  // ****************************************
  pfcsv_cnt_t filt_cnt_reg;
  pfcsv_cnt_t leb_cnt_reg;
  logic ocp_filt;
  logic ocp_seen_reg;
  logic [3:0] coil_cnt_reg;
  logic coil_trip;
  logic boost_allow;
  assign ocp_filt = filt_cnt_reg == 12'(FILT_C);
  assign boost_allow = !prot_act && pfc_run_reg && !bo_stop_reg && !ovp_inh_reg;
  assign coil_trip = boost_cycle_start_i && (ocp_seen_reg || ocp_filt)
                     && (coil_cnt_reg + 4'h1 >= ctrl_reg[`PFCSV_CTRL_COIL_LSB +: 4]);

  always_ff @(posedge clk_i) begin
    if (rst_i || !boost_current_sense_pin_i) begin
      filt_cnt_reg <= 12'h000;
    end else if (!ocp_filt) begin
      filt_cnt_reg <= filt_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_gate_o <= 1'b0;
    end else if (!boost_allow || !boost_on_req_i || ocp_filt) begin
      boost_gate_o <= 1'b0;
    end else if (boost_cycle_start_i) begin
      boost_gate_o <= 1'b1;
    end
  end

  // Counts consecutive cycles that all saw overcurrent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocp_seen_reg <= 1'b0;
      coil_cnt_reg <= 4'h0;
    end else if (boost_cycle_start_i) begin
      ocp_seen_reg <= 1'b0;
      coil_cnt_reg <= (ocp_seen_reg || ocp_filt) ? coil_cnt_reg + 4'h1 : 4'h0;
    end else if (ocp_filt) begin
      ocp_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      leb_cnt_reg <= 12'h000;
    end else if (boost_gate_o && !boost_allow | !boost_on_req_i | ocp_filt) begin
      leb_cnt_reg <= 12'(LEB_C);
    end else if (leb_cnt_reg != 12'h000) begin
      leb_cnt_reg <= leb_cnt_reg - 12'h001;
    end
  end

  // ****************************************
  // Resonant half-bridge gates
  // ****************************************
  logic llc_allow;
  logic llc_ocp_now;
  logic [1:0] side_req;
  logic [1:0] side_gate;
  logic [1:0] beyond;
  assign llc_ocp_now = resonant_current_sense_pin_i > `PFCSV_LLC_OCP;
  assign llc_allow = !prot_act && pfc_run_reg && llc_run_reg && !p_hit[P_BOLLC] && !p_hit[P_OVP];
  assign side_req = {low_side_req_i, high_side_req_i && !high_side_supply_low_i};
  assign beyond[0] = resonant_current_sense_pin_i > $signed(capav_reg[25:16]);
  assign beyond[1] = resonant_current_sense_pin_i < $signed(capav_reg[9:0]);
  assign high_side_gate_o = side_gate[0];
  assign low_side_gate_o = side_gate[1];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_side
      logic armed_reg;
      logic cut_reg;
      logic g_reg;
      logic cut_now;
      // Arm only once current has swung out, else turn-on would trip it
      assign cut_now = g_reg && ((armed_reg && !beyond[g]) || llc_ocp_now);
      always_ff @(posedge clk_i) begin
        if (rst_i || !side_req[g]) begin
          armed_reg <= 1'b0;
          cut_reg <= 1'b0;
          g_reg <= 1'b0;
        end else begin
          armed_reg <= armed_reg | (g_reg & beyond[g]);
          cut_reg <= cut_reg | cut_now;
          g_reg <= llc_allow && !cut_reg && !cut_now && !llc_ocp_now;
        end
      end
      assign side_gate[g] = g_reg;
    end
  endgenerate

  // ****************************************
  // Protection flags
  // ****************************************
  assign p_cond[P_FLR] = ctrl_reg[`PFCSV_CTRL_FD_CLR] && !ctrl_reg[`PFCSV_CTRL_FD_PROT]
                         && (boost_sense_pin_i < `PFCSV_SCP_STOP);
  assign p_cond[P_BO] = !bo_stop_reg && (peak_reg < mains_reg[9:0]);
  assign p_cond[P_BOLLC] = bo_stop_reg && ctrl_reg[`PFCSV_CTRL_BO_LLC];
  assign p_cond[P_OVP] = ovp_inh_reg && ctrl_reg[`PFCSV_CTRL_OVP_LLC];
  assign p_cond[P_DRAIN] = boost_drain_pin_i && (leb_cnt_reg == 12'h000) && !boost_gate_o;
  assign p_cond[P_SUP] = ctrl_reg[`PFCSV_CTRL_SUP_EN] && (ic_supply_pin_i > supply_reg[7:0]);
  assign p_cond[P_LOCP] = ctrl_reg[`PFCSV_CTRL_LOCP_EN] && llc_ocp_now;

  assign flags_set = {p_hit[P_LOCP], p_hit[P_SUP], coil_trip, p_hit[P_DRAIN],
                      fd_event && ctrl_reg[`PFCSV_CTRL_FD_PROT], otp_trip};
  assign flags_clr = (wb_req && wb_we_i && wb_adr_i == `PFCSV_FLAGS_OFS && wb_sel_i[0])
                     ? wb_dat_i[5:0] : 6'h00;
  assign prot_act = |flags_reg;

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= 6'h00;
    end else if (p_hit[P_FLR]) begin
      flags_reg <= flags_set;
    end else begin
      flags_reg <= flags_set | (flags_reg & ~flags_clr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      protection_o <= 1'b0;
    end else begin
      protection_o <= prot_act;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_hs_supply_low: assert property (@(posedge clk_i) disable iff (rst_i)
    high_side_supply_low_i |=> !high_side_gate_o) else $error("high side on with low supply");
  chk_prot_gates_off: assert property (@(posedge clk_i) disable iff (rst_i)
    prot_act |=> !boost_gate_o && !high_side_gate_o && !low_side_gate_o)
    else $error("gate on during protection");
  chk_ntc_max_time: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ntc_source_en_o) |-> ##[1:NTC_MAX_C] !ntc_source_en_o)
    else $error("thermistor source on too long");
  chk_ntc_off_det: assert property (@(posedge clk_i) disable iff (rst_i)
    ntc_source_en_o && !ntc_low |=> !ntc_source_en_o) else $error("source not released");
  chk_boost_ovp_inh: assert property (@(posedge clk_i) disable iff (rst_i)
    boost_sense_pin_i > `PFCSV_OVP_STOP |-> ##2 !boost_gate_o) else $error("boost on in ovp");
  chk_llc_uvp_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    boost_sense_pin_i < `PFCSV_BOOST_UVP |-> ##2 !high_side_gate_o && !low_side_gate_o)
    else $error("resonant on below uvp");
  chk_boost_ocp_cut: assert property (@(posedge clk_i) disable iff (rst_i)
    ocp_filt |=> !boost_gate_o) else $error("boost not cut on overcurrent");
  chk_llc_ocp_cut: assert property (@(posedge clk_i) disable iff (rst_i)
    llc_ocp_now |=> !high_side_gate_o && !low_side_gate_o) else $error("resonant ocp not cut");
  chk_coil_protect: assert property (@(posedge clk_i) disable iff (rst_i)
    coil_trip |=> flags_reg[3] && protection_o == $past(prot_act)) else $error("coil trip lost");
  chk_flags_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    otp_trip |=> flags_reg[0]) else $error("over-temperature flag lost");
  chk_no_start_scp: assert property (@(posedge clk_i) disable iff (rst_i)
    !pfc_run_reg |=> !boost_gate_o && !high_side_gate_o && !low_side_gate_o)
    else $error("switching before short start");
  chk_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");

endmodule // pfcsv_top

//--- tb/pfcsv_stage_model.sv
// Behavioural power stage: mains sense divider and boost cycle timing
`timescale 1ns/1ps
module pfcsv_stage_model #(
  parameter int RES_MOHM = 20,
  parameter int RES_COUNT = 1,
  parameter int CFG_MOHM = 20,
  parameter int CFG_COUNT = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [9:0] mains_sense_pin_o,
  output logic boost_cycle_start_o,
  output logic boost_on_req_o
);
  logic [7:0] phase_reg;
  logic [9:0] tri_v;
  assign tri_v = phase_reg[7] ? {1'b0, ~phase_reg[6:0], 2'h0} : {1'b0, phase_reg[6:0], 2'h0};
  // Divider settings must match the fitted parts or the peak scales wrongly
  assign mains_sense_pin_o = 10'((tri_v * RES_COUNT * CFG_MOHM) / (CFG_COUNT * RES_MOHM));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 8'h00;
      boost_cycle_start_o <= 1'b0;
      boost_on_req_o <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 8'h01;
      boost_cycle_start_o <= (phase_reg[4:0] == 5'h1F);
      boost_on_req_o <= (phase_reg[4:0] == 5'h1F) || (boost_on_req_o && phase_reg[4:0] < 5'h0B);
    end
  end
endmodule // pfcsv_stage_model

//--- tb/pfcsv_tb_top.sv
// Self-checking bench for the protection supervisor
`timescale 1ns/1ps
`include "pfcsv_defs.svh"
module pfcsv_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, ic = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, x;
  logic [9:0] bst = 10'h020, mains;
  logic signed [9:0] res_i = 10'sh000;
  logic hsr = 1'b0, lsr = 1'b0, hsl = 1'b0, drn = 1'b0, ocp = 1'b0;
  logic cs, onr, ack, ntc, bg, hg, lg, ss, prot;
  wire [5:0] outs = {ntc, prot, ss, lg, hg, bg};
  integer n_mismatch = 0, cmp_count = 0, seed = 9, i;
  always #2.5 clk_i = ~clk_i;
  pfcsv_stage_model model (.clk_i(clk_i), .rst_i(rst_i), .mains_sense_pin_o(mains),
    .boost_cycle_start_o(cs), .boost_on_req_o(onr));
  pfcsv_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mains_sense_pin_i(mains), .boost_sense_pin_i(bst), .ic_supply_pin_i(ic),
    .boost_drain_pin_i(drn), .boost_current_sense_pin_i(ocp), .boost_cycle_start_i(cs),
    .boost_on_req_i(onr), .resonant_current_sense_pin_i(res_i), .high_side_req_i(hsr),
    .low_side_req_i(lsr), .high_side_supply_low_i(hsl), .ntc_source_en_o(ntc),
    .boost_gate_o(bg), .high_side_gate_o(hg), .low_side_gate_o(lg),
    .boost_soft_stop_o(ss), .protection_o(prot));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rst_val(input logic [7:0] a);
    case (a)
      `PFCSV_CTRL_OFS: return `PFCSV_CTRL_RST;
      `PFCSV_MAINS_OFS: return `PFCSV_MAINS_RST;
      `PFCSV_SUPPLY_OFS: return `PFCSV_SUPPLY_RST;
      `PFCSV_CAPAV_OFS: return `PFCSV_CAPAV_RST;
      default: return 32'h0;
    endcase
  endfunction
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wait_out(input int b, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && outs[b] !== v; k++) @(posedge clk_i);
    chk(outs[b], v);
  endtask
  // Skips the input-to-gate latency, then checks every cycle
  task hold_out(input int b, input logic v, input int n);
    repeat (3) @(posedge clk_i);
    repeat (n) begin
      @(posedge clk_i);
      chk(outs[b], v);
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 28; i += 4) begin
      if (i != 16) begin
        wb(1'b0, i[7:0], 32'h0);
        chk(q, rst_val(i[7:0]));
      end
    end
    repeat (4) begin
      x = $random(seed);
      wb(1'b1, `PFCSV_SUPPLY_OFS, x);
      wb(1'b0, `PFCSV_SUPPLY_OFS, 32'h0);
      chk(q, x & `PFCSV_SUPPLY_MASK);
      wb(1'b1, 8'h18, x);
      wb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0);
    end
    wb(1'b1, `PFCSV_SUPPLY_OFS, `PFCSV_SUPPLY_RST);
    lsr <= 1'b1;
    ic <= {2'b00, x[5:0]};
    hold_out(0, 1'b0, 40);
    hold_out(2, 1'b0, 40);
    bst <= 10'h300;
    wait_out(3, 1'b0, 3000);
    wait_out(0, 1'b1, 200);
    wait_out(2, 1'b1, 20);
    lsr <= 1'b0;
    hsr <= 1'b1;
    hsl <= 1'b1;
    hold_out(1, 1'b0, 20);
    hsl <= 1'b0;
    wait_out(1, 1'b1, 10);
    res_i <= 10'sh1D0;
    wait_out(1, 1'b0, 4);
    hsr <= 1'b0;
    res_i <= 10'sh000;
    bst <= 10'h370;
    hold_out(0, 1'b0, 60);
    bst <= 10'h340;
    hold_out(0, 1'b0, 60);
    bst <= 10'h300;
    wait_out(0, 1'b1, 100);
    ic <= 8'hE0;
    hold_out(4, 1'b0, 900);
    wait_out(4, 1'b1, 200);
    wb(1'b0, `PFCSV_FLAGS_OFS, 32'h0);
    chk(q, 32'h10);
    ic <= 8'h40;
    wb(1'b1, `PFCSV_FLAGS_OFS, 32'h10);
    wb(1'b0, `PFCSV_FLAGS_OFS, 32'h0);
    chk(q, 32'h0);
    wait_out(4, 1'b0, 5);
    wait_out(5, 1'b1, 300);
    wait_out(5, 1'b0, 900);
    ocp <= 1'b1;
    wait_out(4, 1'b1, 400);
    chk(bg, 1'b0);
    wb(1'b0, `PFCSV_FLAGS_OFS, 32'h0);
    chk(q, 32'h08);
    ocp <= 1'b0;
    // Let two cycle starts flush the coil counter before clearing
    repeat (70) @(posedge clk_i);
    wb(1'b1, `PFCSV_FLAGS_OFS, 32'h08);
    wait_out(4, 1'b0, 5);
    wb(1'b1, `PFCSV_CTRL_OFS, 32'h831);
    bst <= 10'h010;
    wait_out(4, 1'b1, 10);
    wb(1'b0, `PFCSV_FLAGS_OFS, 32'h0);
    chk(q, 32'h02);
    wb(1'b1, `PFCSV_CTRL_OFS, 32'h832);
    wait_out(4, 1'b0, 2100);
    bst <= 10'h300;
    wait_out(0, 1'b1, 100);
    end_sim;
  end
endmodule // pfcsv_tb_top
